// ### core/tsm_monitor.sv
// Fault monitor core for an eighteen channel cabinet signal monitor.
// Assumes all inputs are synchronous to clk and already qualified as levels.
//
// What this block does
// R1 - Watchdog lamp steady on controller watchdog fault
// R2 - Watchdog lamp blinks when monitoring disabled
// R3 - Diagnostic lamp on any self fault
// R4 - Absent-signal lamp lit or blinking when inhibited
// R5 - Double-indication lamp on either double fault
// R6 - Clearance lamp on short yellow clearance
// R7 - Card-ajar lamp; blinks event number in diagnostics
// R8 - Recurring-pulse lamp on pulse-caused faults
// R9 - Status lamps mirror active field signals
// R10 - Fault display: snapshot six seconds, involved two
// R11 - Edge-triggered resets light all lamps 300 ms
// R12 - Sample field inputs 32 times per cycle
// R13 - Processor pulse missing 300 ms forces fault
// R14 - Supervisor recovers, or latches when configured
// R15 - Internal supply failure forces fault
// R16 - Eighteen channels, green yellow red each
// R17 - Latching conflict fault from permissive matrix
// R18 - Conflict qualifies between 200 and 500 ms
// R19 - DC supply fault qualifies 200 to 500 ms
// R20 - Watchdog fault latches; brownout keeps lamp
// R21 - Watchdog latch option ignores brownout recovery
// R22 - Watchdog recognition time 1000 or 1500 ms
// R23 - Watchdog switch off inhibits monitoring
// R24 - One millisecond timebase drives all timing except the field sample strobe
// R25 - Relay and halt asserted and released together
`timescale 1ns/1ps
module tsm_monitor #(
   parameter int MS_CYCLES = tsm_pkg::MS_CYCLES,
   parameter int SAMPLE_CYCLES = tsm_pkg::SAMPLE_CYCLES
) (
   input logic clk,
   input logic rst,
   input tsm_pkg::tsm_field_s field_in,
   input tsm_pkg::tsm_matrix_t compat_matrix,
   input logic dc_supply_low,
   input logic controller_watchdog,
   input logic watchdog_monitor_switch,
   input logic line_below_watchdog_level,
   input logic watchdog_latch_option,
   input logic watchdog_long_time,
   input logic brownout_restore,
   input logic processor_pulse,
   input logic supervisor_latch_option,
   input logic internal_supply_fail,
   input logic memory_test_fail,
   input logic missing_signal_fault,
   input logic green_yellow_double,
   input logic any_pair_double,
   input logic clearance_fault,
   input logic recurring_pulse_fault,
   input logic red_monitor_permit,
   input logic function_override,
   input logic auxiliary_disable_input,
   input logic card_absent,
   input logic diag_display_mode,
   input logic [1:0] diag_event_number,
   input logic reset_button,
   input logic external_reset,
   output logic relay_deenergize,
   output logic controller_halt,
   output tsm_pkg::tsm_lamps_s lamps,
   output tsm_pkg::tsm_field_s status_lamps,
   output logic rms_sample_strobe
);
   import tsm_pkg::*;

   // ------------------------------------------------------------
   // Common millisecond timebase and field sample strobe
   // ------------------------------------------------------------
   logic [MS_CNT_W-1:0] ms_cnt_reg;
   logic ms_tick;
   logic [SAMPLE_CNT_W-1:0] sample_cnt_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ms_cnt_reg <= '0;
      end else if (ms_cnt_reg == MS_CNT_W'(MS_CYCLES - 1)) begin // see R24
         ms_cnt_reg <= '0;
      end else begin
         ms_cnt_reg <= ms_cnt_reg + 17'd1;
      end
   end

   assign ms_tick = (ms_cnt_reg == MS_CNT_W'(MS_CYCLES - 1));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sample_cnt_reg <= '0;
         rms_sample_strobe <= 1'b0;
      end else if (sample_cnt_reg == SAMPLE_CNT_W'(SAMPLE_CYCLES - 1)) begin
         sample_cnt_reg <= '0;
         rms_sample_strobe <= 1'b1; // see R12
      end else begin
         sample_cnt_reg <= sample_cnt_reg + 16'd1;
         rms_sample_strobe <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Blink phase, shared by all flashing lamps
   // ------------------------------------------------------------
   logic [TIME_W-1:0] blink_ms_reg;
   logic blink_once;
   logic event_blink;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         blink_ms_reg <= '0;
      end else if (ms_tick) begin
         if (blink_ms_reg == BLINK_PERIOD_MS - 16'd1) begin
            blink_ms_reg <= '0;
         end else begin
            blink_ms_reg <= blink_ms_reg + 16'd1;
         end
      end
   end

   assign blink_once = (blink_ms_reg < BLINK_ON_MS);

   // Flashes once, twice or three times per period
   always_comb begin
      event_blink = 1'b0;
      if (blink_ms_reg < BLINK_ON_MS && diag_event_number >= 2'd1) begin
         event_blink = 1'b1;
      end else if (blink_ms_reg >= BLINK_SLOT_MS
                   && blink_ms_reg < BLINK_SLOT_MS + BLINK_ON_MS
                   && diag_event_number >= 2'd2) begin
         event_blink = 1'b1;
      end else if (blink_ms_reg >= 16'd2 * BLINK_SLOT_MS
                   && blink_ms_reg < 16'd2 * BLINK_SLOT_MS + BLINK_ON_MS
                   && diag_event_number >= 2'd3) begin
         event_blink = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Reset commands: rising edges only, then a lamp test
   // ------------------------------------------------------------
   logic button_prev_reg;
   logic ext_prev_reg;
   logic reset_cmd;
   logic [TIME_W-1:0] lamp_test_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         button_prev_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
      end else begin
         button_prev_reg <= reset_button;
         ext_prev_reg <= external_reset;
      end
   end

   // A stuck level produces a single command
   assign reset_cmd = (reset_button && !button_prev_reg)
                      || (external_reset && !ext_prev_reg); // see R11

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lamp_test_reg <= '0;
      end else if (reset_cmd) begin
         lamp_test_reg <= LAMP_TEST_MS; // see R11
      end else if (ms_tick && lamp_test_reg != 16'd0) begin
         lamp_test_reg <= lamp_test_reg - 16'd1;
      end
   end

   // ------------------------------------------------------------
   // Conflict detection per channel
   // ------------------------------------------------------------
   logic [NUM_CH-1:0] go_active;
   logic [NUM_CH-1:0] conflict_ch;
   logic conflict_now;

   assign go_active = field_in.green | field_in.yellow; // see R16

   for (genvar i = 0; i < NUM_CH; i++) begin : g_conflict
      logic [NUM_CH-1:0] others;
      assign others = go_active & ~compat_matrix[i] & ~(NUM_CH'(1) << i);
      assign conflict_ch[i] = go_active[i] && (|others); // see R17
   end

   assign conflict_now = |conflict_ch;

   // ------------------------------------------------------------
   // Qualification timers
   // ------------------------------------------------------------
   logic conflict_qual;
   logic dc_qual;
   logic wd_qual;
   logic proc_qual;
   logic wd_monitor_on;
   logic wd_prev_reg;
   logic wd_toggle;
   logic [TIME_W-1:0] wd_limit;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wd_prev_reg <= 1'b0;
      end else begin
         wd_prev_reg <= controller_watchdog;
      end
   end

   assign wd_toggle = controller_watchdog ^ wd_prev_reg;
   assign wd_monitor_on = watchdog_monitor_switch && !line_below_watchdog_level; // see R23
   assign wd_limit = watchdog_long_time ? WD_LONG_MS : WD_SHORT_MS; // see R22

   tsm_qual_timer u_conflict_timer (
      .clk(clk),
      .rst(rst),
      .ms_tick(ms_tick),
      .cond(conflict_now),
      .limit_ms(QUAL_MS), // see R18
      .expired(conflict_qual)
   );

   tsm_qual_timer u_dc_timer (
      .clk(clk),
      .rst(rst),
      .ms_tick(ms_tick),
      .cond(dc_supply_low),
      .limit_ms(QUAL_MS), // see R19
      .expired(dc_qual)
   );

   tsm_qual_timer u_wd_timer (
      .clk(clk),
      .rst(rst),
      .ms_tick(ms_tick),
      .cond(wd_monitor_on && !wd_toggle),
      .limit_ms(wd_limit),
      .expired(wd_qual)
   );

   tsm_qual_timer u_proc_timer (
      .clk(clk),
      .rst(rst),
      .ms_tick(ms_tick),
      .cond(!processor_pulse),
      .limit_ms(PROC_PULSE_MS), // see R13
      .expired(proc_qual)
   );

   // ------------------------------------------------------------
   // Latched faults; a new event wins over a reset command
   // ------------------------------------------------------------
   logic conflict_reg;
   logic dc_reg;
   logic wd_fault_reg;
   logic wd_lamp_reg;
   logic missing_reg;
   logic double_reg;
   logic clearance_reg;
   logic recur_reg;
   logic proc_latch_reg;
   logic proc_fault;
   logic self_fault;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         conflict_reg <= 1'b0;
         dc_reg <= 1'b0;
         missing_reg <= 1'b0;
         double_reg <= 1'b0;
         clearance_reg <= 1'b0;
         recur_reg <= 1'b0;
      end else begin
         conflict_reg <= conflict_qual || (conflict_reg && !reset_cmd); // see R17
         dc_reg <= dc_qual || (dc_reg && !reset_cmd); // see R19
         missing_reg <= missing_signal_fault || (missing_reg && !reset_cmd);
         double_reg <= green_yellow_double || any_pair_double
                       || (double_reg && !reset_cmd);
         clearance_reg <= clearance_fault || (clearance_reg && !reset_cmd);
         recur_reg <= recurring_pulse_fault || (recur_reg && !reset_cmd);
      end
   end

   // Brownout recovery clears the fault unless watchdog_latch_option is set, never the lamp
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wd_fault_reg <= 1'b0;
         wd_lamp_reg <= 1'b0;
      end else begin
         wd_fault_reg <= wd_qual || (wd_fault_reg && !reset_cmd
                         && !(brownout_restore && !watchdog_latch_option)); // see R20 R21
         wd_lamp_reg <= wd_qual || (wd_lamp_reg && !reset_cmd); // see R20
      end
   end

   // Latched supervisor fault needs a power cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         proc_latch_reg <= 1'b0;
      end else if (proc_qual && supervisor_latch_option) begin
         proc_latch_reg <= 1'b1; // see R14
      end
   end

   assign proc_fault = proc_qual || proc_latch_reg; // see R14
   assign self_fault = proc_fault || memory_test_fail || internal_supply_fail; // see R3 R15

   // ------------------------------------------------------------
   // Relay and halt outputs
   // ------------------------------------------------------------
   logic fault_any;

   assign fault_any = conflict_reg || dc_reg || wd_fault_reg || missing_reg
                      || double_reg || clearance_reg || recur_reg
                      || self_fault || card_absent;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         relay_deenergize <= 1'b0;
         controller_halt <= 1'b0;
      end else begin
         relay_deenergize <= fault_any; // see R25 R13 R15
         controller_halt <= fault_any; // see R25 R13 R15
      end
   end

   // ------------------------------------------------------------
   // Fault snapshot and channel status display
   // ------------------------------------------------------------
   tsm_field_s snap_reg;
   logic [NUM_CH-1:0] involved_reg;
   logic [TIME_W-1:0] disp_ms_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         snap_reg <= '0;
         involved_reg <= '0;
      end else if (fault_any && !relay_deenergize) begin
         snap_reg <= field_in; // see R10
         involved_reg <= conflict_ch;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         disp_ms_reg <= '0;
      end else if (!relay_deenergize) begin
         disp_ms_reg <= '0;
      end else if (ms_tick) begin
         if (disp_ms_reg == DISPLAY_CYCLE_MS - 16'd1) begin
            disp_ms_reg <= '0; // see R10
         end else begin
            disp_ms_reg <= disp_ms_reg + 16'd1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_lamps <= '0;
      end else if (lamp_test_reg != 16'd0) begin
         status_lamps <= '1; // see R11
      end else if (!relay_deenergize) begin
         status_lamps <= field_in; // see R9
      end else if (disp_ms_reg < SNAP_SHOW_MS) begin
         status_lamps <= snap_reg; // see R10
      end else begin
         status_lamps.green <= '0;
         status_lamps.yellow <= '0;
         status_lamps.red <= involved_reg; // see R10
      end
   end

   // ------------------------------------------------------------
   // Front panel fault lamps
   // ------------------------------------------------------------
   tsm_lamps_s lamps_next;
   logic absent_inhibit;

   assign absent_inhibit = !red_monitor_permit || function_override
                           || auxiliary_disable_input;

   always_comb begin
      lamps_next = '0;
      if (wd_lamp_reg) begin
         lamps_next.watchdog_error_lamp = 1'b1; // see R1
      end else if (!wd_monitor_on) begin
         lamps_next.watchdog_error_lamp = blink_once; // see R2
      end
      lamps_next.conflict_lamp = conflict_reg;
      lamps_next.diagnostic_lamp = self_fault; // see R3
      if (missing_reg) begin
         lamps_next.absent_signal_lamp = 1'b1; // see R4
      end else if (absent_inhibit) begin
         lamps_next.absent_signal_lamp = blink_once; // see R4
      end
      lamps_next.double_indication_lamp = double_reg; // see R5
      lamps_next.clearance_lamp = clearance_reg; // see R6
      if (diag_display_mode) begin
         lamps_next.card_ajar_lamp = event_blink; // see R7
      end else begin
         lamps_next.card_ajar_lamp = card_absent; // see R7
      end
      lamps_next.recurring_pulse_lamp = recur_reg; // see R8
      lamps_next.dc_fail_lamp = dc_reg;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lamps <= '0;
      end else if (lamp_test_reg != 16'd0) begin
         lamps <= '1; // see R11
      end else begin
         lamps <= lamps_next;
      end
   end
endmodule

// ### shared/tsm_pkg.sv
// Constants and carrier types for the cabinet signal fault monitor.
// Assumes a single 100 MHz system clock.
package tsm_pkg;

   // ------------------------------------------------------------
   // Clock and timebase
   // ------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int MS_PER_S = 1000;
   localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
   localparam int MS_CNT_W = 17;
   localparam int TIME_W = 16;

   // ------------------------------------------------------------
   // Channels and field sampling
   // ------------------------------------------------------------
   localparam int NUM_CH = 18;
   localparam int LINE_HZ = 60;
   localparam int SAMPLES_PER_CYCLE = 32;
   localparam int SAMPLE_CYCLES = CLK_HZ / (LINE_HZ * SAMPLES_PER_CYCLE);
   localparam int SAMPLE_CNT_W = 16;

   // ------------------------------------------------------------
   // Times in milliseconds
   // ------------------------------------------------------------
   localparam logic [TIME_W-1:0] QUAL_NEVER_MS = 16'd200;
   localparam logic [TIME_W-1:0] QUAL_ALWAYS_MS = 16'd500;
   localparam logic [TIME_W-1:0] QUAL_MS = (QUAL_NEVER_MS + QUAL_ALWAYS_MS) / 16'd2;
   localparam logic [TIME_W-1:0] WD_SHORT_MS = 16'd1000;
   localparam logic [TIME_W-1:0] WD_LONG_MS = 16'd1500;
   localparam logic [TIME_W-1:0] PROC_PULSE_MS = 16'd300;
   localparam logic [TIME_W-1:0] LAMP_TEST_MS = 16'd300;
   localparam logic [TIME_W-1:0] BLINK_PERIOD_MS = 16'd2000;
   localparam logic [TIME_W-1:0] BLINK_ON_MS = 16'd250;
   localparam logic [TIME_W-1:0] BLINK_SLOT_MS = 16'd500;
   localparam logic [TIME_W-1:0] SNAP_SHOW_MS = 16'd6000;
   localparam logic [TIME_W-1:0] INVOLVED_SHOW_MS = 16'd2000;
   localparam logic [TIME_W-1:0] DISPLAY_CYCLE_MS = SNAP_SHOW_MS + INVOLVED_SHOW_MS;

   // ------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [NUM_CH-1:0] green;
      logic [NUM_CH-1:0] yellow;
      logic [NUM_CH-1:0] red;
   } tsm_field_s;

   typedef struct packed {
      logic watchdog_error_lamp;
      logic conflict_lamp;
      logic diagnostic_lamp;
      logic absent_signal_lamp;
      logic double_indication_lamp;
      logic clearance_lamp;
      logic card_ajar_lamp;
      logic recurring_pulse_lamp;
      logic dc_fail_lamp;
   } tsm_lamps_s;

   typedef logic [NUM_CH-1:0][NUM_CH-1:0] tsm_matrix_t;

endpackage

// ### core/tsm_qual_timer.sv
// Qualification timer: raises expired once cond has held for limit_ms.
// Assumes a one-cycle millisecond tick from the common timebase.
`timescale 1ns/1ps
module tsm_qual_timer (
   input logic clk,
   input logic rst,
   input logic ms_tick,
   input logic cond,
   input logic [tsm_pkg::TIME_W-1:0] limit_ms,
   output logic expired
);
   import tsm_pkg::*;

   logic [TIME_W-1:0] count_reg;

   // ------------------------------------------------------------
   // Count whole milliseconds of a persisting condition
   // ------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_reg <= '0;
      end else if (!cond) begin
         count_reg <= '0;
      end else if (ms_tick && count_reg < limit_ms) begin
         count_reg <= count_reg + 16'd1;
      end
   end

   assign expired = cond && (count_reg >= limit_ms);
endmodule

// ### tb/tsm_ctrl_model.sv
// Controller side model: watchdog toggle and processor heartbeat.
// Assumes the monitor clock and a millisecond of MS_CYCLES clocks.
`timescale 1ns/1ps
module tsm_ctrl_model #(
   parameter int MS_CYCLES = 10
) (
   input logic clk,
   input logic rst,
   input logic wd_run,
   input logic proc_run,
   output logic controller_watchdog,
   output logic processor_pulse
);
   logic [31:0] cnt_reg;
   // ----------------------------------------
   // One event every 100 ms
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= '0;
         controller_watchdog <= 1'b0;
         processor_pulse <= 1'b0;
      end else begin
         cnt_reg <= (cnt_reg == 100 * MS_CYCLES - 1) ? '0 : cnt_reg + 32'h1;
         processor_pulse <= proc_run && cnt_reg == '0;
         if (wd_run && cnt_reg == '0) begin
            controller_watchdog <= ~controller_watchdog;
         end
      end
   end
endmodule

// ### tb/tsm_monitor_sva.sv
// Checker for the monitor's ports.
// Assumes the monitor's MS_CYCLES and SAMPLE_CYCLES are handed on.
`timescale 1ns/1ps
module tsm_monitor_sva #(
   parameter int MS_CYCLES = 10,
   parameter int SAMPLE_CYCLES = 8
) (
   input logic clk,
   input logic rst,
   input tsm_pkg::tsm_field_s field_in,
   input logic dc_supply_low,
   input logic internal_supply_fail,
   input logic memory_test_fail,
   input logic card_absent,
   input logic reset_button,
   input logic external_reset,
   input logic relay_deenergize,
   input logic controller_halt,
   input tsm_pkg::tsm_lamps_s lamps,
   input tsm_pkg::tsm_field_s status_lamps,
   input logic rms_sample_strobe
);
   import tsm_pkg::*;
   logic [31:0] dc_cnt_reg;
   logic [31:0] gap_reg;
   logic seen_reg;
   logic test_on;
   assign test_on = lamps == 9'h1ff;
   // ----------------------------------------
   // Helper counters
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dc_cnt_reg <= '0;
      end else begin
         dc_cnt_reg <= dc_supply_low ? dc_cnt_reg + 32'h1 : '0;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gap_reg <= '0;
         seen_reg <= 1'b0;
      end else begin
         gap_reg <= rms_sample_strobe ? '0 : gap_reg + 32'h1;
         seen_reg <= seen_reg | rms_sample_strobe;
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   chk_halt_with_relay: assert property (controller_halt == relay_deenergize)
      else $error("halt differs from relay");
   chk_sample_period: assert property (rms_sample_strobe && seen_reg |->
      gap_reg == SAMPLE_CYCLES - 1) else $error("sample strobe spacing wrong");
   chk_card_relay: assert property (card_absent |=> relay_deenergize)
      else $error("card fault without relay");
   chk_self_diag: assert property ((internal_supply_fail || memory_test_fail) |->
      ##[1:2] lamps.diagnostic_lamp) else $error("diagnostic lamp dark");
   chk_supply_relay: assert property (internal_supply_fail |=>
      relay_deenergize && controller_halt) else $error("supply fault without relay");
   chk_lamp_test: assert property (($rose(reset_button) || $rose(external_reset)) |->
      ##[1:2] (lamps == 9'h1ff)[*8]) else $error("lamp test missing");
   chk_conflict_relay: assert property ($rose(lamps.conflict_lamp) && !test_on |->
      relay_deenergize) else $error("conflict lamp without relay");
   chk_status_mirror: assert property (!relay_deenergize && !$past(relay_deenergize) &&
      !test_on |-> status_lamps == $past(field_in)) else $error("status not mirrored");
   chk_dc_not_early: assert property ($rose(lamps.dc_fail_lamp) && !test_on |->
      dc_cnt_reg >= 200 * MS_CYCLES) else $error("dc fault too early");
   chk_dc_not_late: assert property (dc_cnt_reg == 500 * MS_CYCLES |->
      relay_deenergize) else $error("dc fault too late");
   cover property ($rose(lamps.conflict_lamp));
   cover property ($rose(lamps.dc_fail_lamp));
   cover property ($fell(relay_deenergize));
endmodule

bind tsm_monitor tsm_monitor_sva #(.MS_CYCLES(MS_CYCLES), .SAMPLE_CYCLES(SAMPLE_CYCLES))
   tsm_monitor_sva_inst (.*);

// ### tb/tsm_monitor_tb.sv
// Self-checking bench for the monitor with a controller model.
// Assumes shortened timebase: 10 clocks per millisecond.
`timescale 1ns/1ps
module tsm_monitor_tb;
   import tsm_pkg::*;
   localparam int MS = 10;
   logic clk = 1'b0, rst = 1'b1;
   tsm_field_s field_in = '0, status_lamps, snap;
   tsm_matrix_t compat_matrix = '1;
   tsm_lamps_s lamps;
   logic dc_supply_low = 1'b0, watchdog_monitor_switch = 1'b1, watchdog_latch_option = 1'b0;
   logic watchdog_long_time = 1'b0, brownout_restore = 1'b0, internal_supply_fail = 1'b0;
   logic memory_test_fail = 1'b0, red_monitor_permit = 1'b1, function_override = 1'b0;
   logic auxiliary_disable_input = 1'b0, card_absent = 1'b0, reset_button = 1'b0;
   logic external_reset = 1'b0, wd_run = 1'b1, proc_run = 1'b1, diag_display_mode = 1'b0;
   logic line_below_watchdog_level = 1'b0, supervisor_latch_option = 1'b0, rms_sample_strobe;
   logic controller_watchdog, processor_pulse, relay_deenergize, controller_halt;
   logic [1:0] diag_event_number = '0;
   logic [4:0] evt = '0;
   logic [63:0] rnd;
   int miscompares = 0, checked = 0, cycles = 0, seed, on_wd, on_abs, on_pca;
   always #5 clk = ~clk;
   tsm_ctrl_model #(.MS_CYCLES(MS)) tsm_ctrl_model_inst (.*);
   tsm_monitor #(.MS_CYCLES(MS), .SAMPLE_CYCLES(8)) tsm_monitor_inst (.*,
      .missing_signal_fault(evt[0]), .green_yellow_double(evt[1]), .any_pair_double(evt[2]),
      .clearance_fault(evt[3]), .recurring_pulse_fault(evt[4]));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic complete_run();
      if (miscompares == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 95000) begin
         miscompares++;
         complete_run();
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rcmd(input logic ext);
      {external_reset, reset_button} = ext ? 2'h2 : 2'h1;
      cyc(2);
      chk(lamps, 9'h1ff);
      chk(&status_lamps, 1'b1);
      cyc(310 * MS);
      chk({relay_deenergize, lamps}, 10'h000);
      {external_reset, reset_button} = 2'h0;
      cyc(1);
   endtask
   task automatic brown();
      brownout_restore = 1'b1;
      cyc(1);
      brownout_restore = 1'b0;
      cyc(5);
   endtask
   function automatic logic [8:0] exp_lamp(input int k);
      return 9'h1 << ((k == 0) ? 5 : (k < 3) ? 4 : (k == 3) ? 3 : 1);
   endfunction
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      seed = 56;
      cyc(5);
      rst = 1'b0;
      cyc(1);
      for (int i = 0; i < 20; i++) begin
         rnd = {$random(seed), $random(seed)};
         field_in = rnd[53:0];
         cyc(1);
         chk(status_lamps, field_in);
      end
      field_in = '0;
      compat_matrix[0][1] = 1'b0;
      compat_matrix[1][0] = 1'b0;
      field_in.green[1:0] = 2'h3;
      cyc(190 * MS);
      field_in = '0;
      cyc(MS);
      chk(relay_deenergize, 1'b0);
      field_in.yellow[0] = 1'b1;
      field_in.green[1] = 1'b1;
      cyc(510 * MS);
      snap = field_in;
      field_in = '0;
      cyc(100 * MS);
      chk({relay_deenergize, controller_halt, lamps.conflict_lamp}, 3'h7);
      chk(status_lamps, snap);
      rcmd(1'b0);
      dc_supply_low = 1'b1;
      cyc(150 * MS);
      dc_supply_low = 1'b0;
      cyc(MS);
      chk(lamps.dc_fail_lamp, 1'b0);
      dc_supply_low = 1'b1;
      cyc(510 * MS);
      dc_supply_low = 1'b0;
      chk({relay_deenergize, lamps.dc_fail_lamp}, 2'h3);
      rcmd(1'b1);
      watchdog_long_time = 1'b1;
      wd_run = 1'b0;
      cyc(1200 * MS);
      chk(relay_deenergize, 1'b0);
      cyc(400 * MS);
      chk({relay_deenergize, lamps.watchdog_error_lamp}, 2'h3);
      wd_run = 1'b1;
      cyc(110 * MS);
      brown();
      chk({relay_deenergize, lamps.watchdog_error_lamp}, 2'h1);
      watchdog_long_time = 1'b0;
      watchdog_latch_option = 1'b1;
      wd_run = 1'b0;
      cyc(1100 * MS);
      chk(relay_deenergize, 1'b1);
      wd_run = 1'b1;
      cyc(110 * MS);
      brown();
      chk(relay_deenergize, 1'b1);
      watchdog_latch_option = 1'b0;
      rcmd(1'b1);
      watchdog_monitor_switch = 1'b0;
      line_below_watchdog_level = 1'b1;
      diag_display_mode = 1'b1;
      diag_event_number = 2'h2;
      red_monitor_permit = 1'b0;
      function_override = 1'b1;
      auxiliary_disable_input = 1'b1;
      wd_run = 1'b0;
      on_wd = 0;
      on_abs = 0;
      on_pca = 0;
      repeat (2000 * MS) begin
         cyc(1);
         on_wd += lamps.watchdog_error_lamp;
         on_abs += lamps.absent_signal_lamp;
         on_pca += lamps.card_ajar_lamp;
      end
      chk(on_pca, 500 * MS);
      chk(on_wd, 250 * MS);
      chk(on_abs, 250 * MS);
      chk(relay_deenergize, 1'b0);
      watchdog_monitor_switch = 1'b1;
      line_below_watchdog_level = 1'b0;
      diag_display_mode = 1'b0;
      red_monitor_permit = 1'b1;
      function_override = 1'b0;
      auxiliary_disable_input = 1'b0;
      wd_run = 1'b1;
      proc_run = 1'b0;
      cyc(320 * MS);
      chk({relay_deenergize, controller_halt, lamps.diagnostic_lamp}, 3'h7);
      proc_run = 1'b1;
      cyc(110 * MS);
      chk({relay_deenergize, lamps.diagnostic_lamp}, 2'h0);
      supervisor_latch_option = 1'b1;
      proc_run = 1'b0;
      cyc(320 * MS);
      proc_run = 1'b1;
      cyc(110 * MS);
      chk(relay_deenergize, 1'b1);
      rst = 1'b1;
      cyc(1);
      {rst, supervisor_latch_option} = 2'h0;
      cyc(2);
      chk({relay_deenergize, lamps}, 10'h000);
      internal_supply_fail = 1'b1;
      cyc(2);
      chk({relay_deenergize, lamps.diagnostic_lamp}, 2'h3);
      internal_supply_fail = 1'b0;
      memory_test_fail = 1'b1;
      cyc(2);
      chk(lamps.diagnostic_lamp, 1'b1);
      memory_test_fail = 1'b0;
      card_absent = 1'b1;
      cyc(2);
      chk({relay_deenergize, lamps.card_ajar_lamp}, 2'h3);
      card_absent = 1'b0;
      for (int k = 0; k < 5; k++) begin
         evt = 5'h01 << k;
         cyc(1);
         evt = '0;
         cyc(2);
         chk(lamps & exp_lamp(k), exp_lamp(k));
      end
      chk(relay_deenergize, 1'b1);
      rcmd(1'b0);
      complete_run();
   end
endmodule
